// [rtl/rpc_top.sv]
// Redundancy and power control register with APB slave
// Assumes APB master on clk; transmit enable pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module rpc_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] transmit_enable_pin,
	output logic [2:0] receive_section_on,
	output logic [2:0] transmit_driver_on,
	output logic [2:0] transmit_line_oe
);
	logic [7:0] redundancy_control_register;
	logic [7:0] next_redundancy_control_register;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [2:0] next_receive_section_on;
	logic [2:0] next_transmit_line_oe;
	logic [2:0] pin_level;
	logic [2:0] drv_on;
	logic access;
	logic hit_ctrl;
	logic hit_status;

	assign access = psel & penable & ~pready;
	assign hit_ctrl = (paddr == rpc_pkg::rpc_ctrl_offset);
	assign hit_status = (paddr == rpc_pkg::rpc_status_offset);

	for (genvar ch = 0; ch < 3; ch++) begin : g_ch
		rpc_pin_sync u_sync (
			.clk(clk),
			.reset_n(reset_n),
			.pin_async(transmit_enable_pin[ch]),
			.pin_level(pin_level[ch])
		);
		rpc_tx_gate u_gate (
			.clk(clk),
			.reset_n(reset_n),
			.reg_on(redundancy_control_register[rpc_pkg::rpc_tx_on_lsb + ch]),
			.pin_on(pin_level[ch]),
			.driver_on(drv_on[ch])
		);
	end

	// Register write and APB answer
	always_comb begin
		next_redundancy_control_register = redundancy_control_register;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel & penable & pready) begin
			next_prdata = 32'h0000_0000;
		end
		if (access) begin
			next_pready = 1'b1;
			next_prdata = 32'h0000_0000;
			if (hit_ctrl) begin
				if (pwrite) begin
					if (pstrb[0]) begin
						next_redundancy_control_register = pwdata[7:0] & rpc_pkg::rpc_ctrl_writable;
					end
				end else begin
					next_prdata = {24'h00_0000, redundancy_control_register};
				end
			end else if (hit_status) begin
				if (pwrite) begin
					next_pslverr = 1'b1;
				end else begin
					next_prdata = {24'h00_0000, 1'b0, drv_on, 1'b0, pin_level};
				end
			end else begin
				next_pslverr = 1'b1;
			end
		end
	end

	always_comb begin
		next_receive_section_on = next_redundancy_control_register[rpc_pkg::rpc_rx_on_lsb +: 3];
		next_transmit_line_oe = drv_on;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			redundancy_control_register <= rpc_pkg::rpc_ctrl_reset;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			receive_section_on <= 3'h0;
			transmit_line_oe <= 3'h0;
		end else begin
			redundancy_control_register <= next_redundancy_control_register;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			receive_section_on <= next_receive_section_on;
			transmit_line_oe <= next_transmit_line_oe;
		end
	end

	assign transmit_driver_on = drv_on;

	// Channel 2 receiver follows bit 6
	chk_rx_ch2_follow: assert property (
		@(posedge clk) disable iff (!reset_n)
		receive_section_on[2] == redundancy_control_register[6]
	) else $error("rx ch2 mismatch");
	// Channel 1 receiver follows bit 5
	chk_rx_ch1_follow: assert property (
		@(posedge clk) disable iff (!reset_n)
		receive_section_on[1] == redundancy_control_register[5]
	) else $error("rx ch1 mismatch");
	// Channel 0 receiver follows bit 4
	chk_rx_ch0_follow: assert property (
		@(posedge clk) disable iff (!reset_n)
		receive_section_on[0] == redundancy_control_register[4]
	) else $error("rx ch0 mismatch");
	chk_rx_off_hold: assert property (
		@(posedge clk) disable iff (!reset_n)
		!redundancy_control_register[4] && !(access && pwrite && hit_ctrl) |=> !receive_section_on[0]
	) else $error("rx ch0 woke without write");
	chk_tx_ch2_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		redundancy_control_register[2] && pin_level[2] && $stable(redundancy_control_register[2])
		|=> transmit_driver_on[2]
	) else $error("tx ch2 not on");
	chk_tx_ch2_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!redundancy_control_register[2] |=> !transmit_driver_on[2] ##1 !transmit_line_oe[2]
	) else $error("tx ch2 not tri-stated");
	chk_tx_ch1_gate: assert property (
		@(posedge clk) disable iff (!reset_n)
		transmit_driver_on[1] |-> $past(redundancy_control_register[1]) && $past(pin_level[1])
	) else $error("tx ch1 wrong");
	chk_tx_ch0_gate: assert property (
		@(posedge clk) disable iff (!reset_n)
		transmit_driver_on[0] |-> $past(redundancy_control_register[0]) && $past(pin_level[0])
	) else $error("tx ch0 wrong");
	chk_reserved_zero: assert property (
		@(posedge clk) disable iff (!reset_n)
		redundancy_control_register[7] == 1'b0 && redundancy_control_register[3] == 1'b0
	) else $error("reserved bit set");
	chk_pin_low_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!pin_level[2] |=> !transmit_driver_on[2]
	) else $error("tx ch2 on with pin low");
	chk_rx_ch2_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && pwdata[6] |=> receive_section_on[2]
	) else $error("rx ch2 not powered");
	chk_rx_ch2_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && !pwdata[6] |=> !receive_section_on[2]
	) else $error("rx ch2 not powered down");
	chk_rx_ch1_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && pwdata[5] |=> receive_section_on[1]
	) else $error("rx ch1 not powered");
	chk_rx_ch1_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && !pwdata[5] |=> !receive_section_on[1]
	) else $error("rx ch1 not powered down");
	chk_rx_ch0_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && pwdata[4] |=> receive_section_on[0]
	) else $error("rx ch0 not powered");
	chk_rx_ch0_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && !pwdata[4] |=> !receive_section_on[0]
	) else $error("rx ch0 not powered down");
	chk_rx_path_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		$fell(redundancy_control_register[5]) |-> !receive_section_on[1]
	) else $error("rx ch1 path still powered");
	// Write with pin high enables driver
	chk_tx_ch2_write_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && pwdata[2] ##1 pin_level[2] |=> transmit_driver_on[2]
	) else $error("tx ch2 not enabled by write");
	chk_tx_ch2_line_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		transmit_driver_on[2] |=> transmit_line_oe[2]
	) else $error("tx ch2 line not driven");
	chk_tx_ch2_line_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!transmit_driver_on[2] |=> !transmit_line_oe[2]
	) else $error("tx ch2 line not released");
	chk_tx_ch2_write_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_ctrl && pstrb[0] && !pwdata[2] |=> ##1 !transmit_driver_on[2]
	) else $error("tx ch2 not shut by write");
	chk_tx_ch1_line: assert property (
		@(posedge clk) disable iff (!reset_n)
		transmit_line_oe[1] == $past(transmit_driver_on[1])
	) else $error("tx ch1 line enable wrong");
	chk_tx_ch0_line: assert property (
		@(posedge clk) disable iff (!reset_n)
		transmit_line_oe[0] == $past(transmit_driver_on[0])
	) else $error("tx ch0 line enable wrong");
	// Channel 1 bit clear shuts driver
	chk_tx_ch1_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!redundancy_control_register[1] |=> !transmit_driver_on[1]
	) else $error("tx ch1 on with bit clear");
	// Channel 0 bit clear shuts driver
	chk_tx_ch0_off: assert property (
		@(posedge clk) disable iff (!reset_n)
		!redundancy_control_register[0] |=> !transmit_driver_on[0]
	) else $error("tx ch0 on with bit clear");
	chk_pin_low_line: assert property (
		@(posedge clk) disable iff (!reset_n)
		!pin_level[2] |=> ##1 !transmit_line_oe[2]
	) else $error("tx ch2 line driven with pin low");
	chk_reset_clear: assert property (
		@(posedge clk)
		!reset_n |=> redundancy_control_register == 8'h00 && receive_section_on == 3'h0
		&& transmit_driver_on == 3'h0 && transmit_line_oe == 3'h0
	) else $error("reset left state set");
	chk_strobe_ignored: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && !pstrb[0] |=> $stable(redundancy_control_register)
	) else $error("write without strobe landed");
	chk_unmapped_keep: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && !hit_ctrl |=> $stable(redundancy_control_register)
	) else $error("foreign access changed register");
	chk_pready_pulse: assert property (
		@(posedge clk) disable iff (!reset_n)
		pready |=> !pready
	) else $error("ready longer than one cycle");
	chk_err_with_ready: assert property (
		@(posedge clk) disable iff (!reset_n)
		pslverr |-> pready
	) else $error("error without ready");
	chk_unmapped_err: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && !hit_ctrl && !hit_status |=> pslverr && prdata == 32'h0000_0000
	) else $error("unmapped access not refused");
	chk_ctrl_read: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && !pwrite && hit_ctrl |=> !pslverr && prdata == {24'h00_0000, $past(redundancy_control_register)}
	) else $error("control read data wrong");
	chk_status_write_err: assert property (
		@(posedge clk) disable iff (!reset_n)
		access && pwrite && hit_status |=> pslverr && $stable(redundancy_control_register)
	) else $error("status write not refused");
	chk_ready_answer: assert property (
		@(posedge clk) disable iff (!reset_n)
		access |=> pready
	) else $error("access not answered");
endmodule
`default_nettype wire

// [rtl/rpc_pkg.sv]
// Constants for the redundancy and power control register block
// Assumes an APB master with 32-bit data and a 20 MHz clock
package rpc_pkg;
	localparam int unsigned rpc_num_channels = 3;
	localparam logic [7:0] rpc_ctrl_offset = 8'h00;
	localparam int unsigned rpc_ctrl_width = 8;
	localparam logic [7:0] rpc_ctrl_reset = 8'h00;
	localparam logic [7:0] rpc_ctrl_writable = 8'h77;
	localparam int unsigned rpc_tx_on_lsb = 0;
	localparam int unsigned rpc_rx_on_lsb = 4;
	localparam logic [7:0] rpc_status_offset = 8'h04;
	localparam int unsigned rpc_status_pin_lsb = 0;
	localparam int unsigned rpc_status_drv_lsb = 4;
	localparam int unsigned rpc_sync_stages = 3;
endpackage

// [rtl/rpc_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
// Assumes an asynchronous level input and the block clock
`timescale 1ns/1ps
`default_nettype none
module rpc_pin_sync (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic pin_async,
	output logic pin_level
);
	logic [2:0] stage;
	logic [2:0] next_stage;
	logic next_pin_level;

	// Stage one is only read by stage two
	always_comb begin
		next_stage = {stage[1:0], pin_async};
		next_pin_level = pin_level;
		if (stage[1] == stage[2]) begin
			next_pin_level = stage[2];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stage <= 3'h0;
			pin_level <= 1'b0;
		end else begin
			stage <= next_stage;
			pin_level <= next_pin_level;
		end
	end
endmodule
`default_nettype wire

// [rtl/rpc_tx_gate.sv]
// Transmit driver gate for one channel
// Assumes synchronised enable pin and register bit on one clock
`timescale 1ns/1ps
`default_nettype none
module rpc_tx_gate (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_on,
	input wire logic pin_on,
	output logic driver_on
);
	logic next_driver_on;

	// Driver on only with pin high and bit set
	always_comb begin
		next_driver_on = reg_on & pin_on;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			driver_on <= 1'b0;
		end else begin
			driver_on <= next_driver_on;
		end
	end
endmodule
`default_nettype wire

// [dv/tb_rpc_top.sv]
// Self-checking bench for the redundancy and power control block
// Assumes rpc_top on a 50 ns clock, driven as an APB master
`timescale 1ns/1ps
`default_nettype none
module tb_rpc_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hf;
	logic [2:0] pins = 3'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic [2:0] rx_on, drv_on, line_oe;
	int n_mismatch = 0;
	int checks_done = 0;
	int cyc = 0;
	always #25 clk = ~clk;
	rpc_top dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .transmit_enable_pin(pins), .receive_section_on(rx_on),
		.transmit_driver_on(drv_on), .transmit_line_oe(line_oe));
	task results;
		$display("Checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, waits for pready
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		// Values read here are those sampled at this edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task setpins(input logic [2:0] v);
		@(posedge clk);
		pins <= v;
	endtask
	task outs(input logic [2:0] r, input logic [2:0] d, input logic [2:0] o);
		chk("receive_section_on", 32'(r), 32'(rx_on));
		chk("transmit_driver_on", 32'(d), 32'(drv_on));
		chk("transmit_line_oe", 32'(o), 32'(line_oe));
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		#1;
		outs(3'h0, 3'h0, 3'h0);
		apb(1'b0, 8'h00, 32'h0000_0000, 4'hf);
		chk("ctrl reset", 32'h0000_0000, rd);
		$display("Test reset done");
		setpins(3'h7);
		apb(1'b1, 8'h00, 32'h0000_00ff, 4'hf);
		chk("write err", 32'h0, 32'(err));
		idle(8);
		outs(3'h7, 3'h7, 3'h7);
		apb(1'b0, 8'h00, 32'h0000_0000, 4'hf);
		chk("ctrl readback", 32'h0000_0077, rd);
		apb(1'b0, 8'h04, 32'h0000_0000, 4'hf);
		chk("status", 32'h0000_0077, rd);
		$display("Test all on done");
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'h00, (32'h0000_0010 << i) | (32'h0000_0001 << i), 4'hf);
			idle(3);
			outs(3'(1 << i), 3'(1 << i), 3'(1 << i));
		end
		$display("Test one channel done");
		apb(1'b1, 8'h00, 32'h0000_0077, 4'hf);
		setpins(3'h3);
		idle(8);
		outs(3'h7, 3'h3, 3'h3);
		apb(1'b0, 8'h04, 32'h0000_0000, 4'hf);
		chk("status pin low", 32'h0000_0033, rd);
		setpins(3'h7);
		apb(1'b1, 8'h00, 32'h0000_0033, 4'hf);
		idle(8);
		outs(3'h3, 3'h3, 3'h3);
		$display("Test pin gate done");
		apb(1'b1, 8'h08, 32'h0000_00ff, 4'hf);
		chk("unmapped write err", 32'h1, 32'(err));
		apb(1'b0, 8'h08, 32'h0000_0000, 4'hf);
		chk("unmapped read err", 32'h1, 32'(err));
		chk("unmapped read data", 32'h0000_0000, rd);
		apb(1'b1, 8'h04, 32'h0000_0000, 4'hf);
		chk("status write err", 32'h1, 32'(err));
		apb(1'b1, 8'h00, 32'h0000_0000, 4'he);
		apb(1'b0, 8'h00, 32'h0000_0000, 4'hf);
		chk("ctrl after refusals", 32'h0000_0033, rd);
		$display("Test refusals done");
		results;
	end
endmodule
`default_nettype wire
